// ---- include/pud_pkg.sv ----
/*
 * Shared constants and carrier types for the port pull-up and direction block.
 * Assumes a 32-bit APB register bus clocked at 100 MHz with byte addresses.
 */
package pud_pkg;

	localparam int          PORT_W      = 8;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          MODE_W      = 3;

	// Register byte offsets.
	localparam logic [7:0]  OFF_PE_DIR  = 8'h00;
	localparam logic [7:0]  OFF_PE_PCR  = 8'h04;
	localparam logic [7:0]  OFF_PF_DIR  = 8'h08;
	localparam logic [7:0]  OFF_CTRL    = 8'h0C;
	localparam logic [7:0]  OFF_STATUS  = 8'h10;

	// Control register fields.
	localparam int          CTRL_BUS16  = 0;
	localparam int          CTRL_EXT_EN = 1;

	// Status register fields.
	localparam int          ST_PULLUP   = 0;
	localparam int          ST_MODE     = 8;
	localparam int          ST_HWSTBY   = 11;
	localparam int          ST_SWSTBY   = 12;

	// Operating mode codes taken from the mode pins.
	localparam logic [2:0]  MODE_1      = 3'h1;
	localparam logic [2:0]  MODE_2      = 3'h2;
	localparam logic [2:0]  MODE_4      = 3'h4;
	localparam logic [2:0]  MODE_7      = 3'h7;

	localparam logic [7:0]  PORT_RST    = 8'h00;
	localparam logic [2:0]  MODE_RST    = MODE_7;
	localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
	localparam int          PIN_SEVEN   = 7;

	// Edges after reset release before the synchronised mode pins are latched.
	localparam logic [2:0]  STRAP_WAIT  = 3'h4;

	typedef struct packed {
		logic ext_exp_en;
		logic bus16;
	} pud_ctrl_t;

	localparam pud_ctrl_t   CTRL_RST    = '{ext_exp_en: 1'b0, bus16: 1'b0};

	typedef struct packed {
		logic              sel;
		logic              enable;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pud_apb_req_t;

endpackage

// ---- verilog/pud_sync.sv ----
/*
 * Three-stage synchroniser for pins arriving from outside the clock domain.
 * Assumes the input is quasi-static; a change is accepted only once the
 * second and third stages agree, so a single metastable sample is filtered.
 */
`timescale 1ns/1ns
`default_nettype none

module pud_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         pclk_en,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_dout;

	always_comb
	begin
		next_dout = dout;
		if (stage2 == stage3)
		begin
			next_dout = stage3;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1 <= RST;
			stage2 <= RST;
			stage3 <= RST;
			dout   <= RST;
		end
		else if (pclk_en)
		begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
			dout   <= next_dout;
		end
	end

endmodule

`default_nettype wire

// ---- verilog/pud_port.sv ----
/*
 * Port E pull-up control and port F direction register, reached over APB.
 * Assumes an APB master on pclk, mode pins that are static straps, and a
 * hardware standby pin from outside the clock domain.
 */
// The register offsets and register access over APB are this design's own decisions.
// Overview of operation
// - Port E pull-ups work in single-chip mode and in 8-bit bus mode; 16-bit expanded mode forces off.
// - Each port E pull-up is switched on or off per pin.
// - In 8-bit mode, pull-up on when direction bit 0 and pull-up bit 1.
// - Reset and hardware standby hold every port E pull-up off.
// - In normal and software standby, pull-up equals not-direction and pull-up bit.
// - Port F is eight general-purpose pins that may serve other functions.
// - Each port F direction bit selects input or output for its pin.
// - Port F direction register is write-only; reads give no defined value.
// - In 8-bit mode, port E direction 1 means output, 0 input.
// - In expanded modes, pin seven drives the system clock when direction bit set.
`timescale 1ns/1ns
`default_nettype none

module pud_port #(
	parameter int PORT_W = pud_pkg::PORT_W
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       pclk_en,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pud_pkg::ADDR_W-1:0] paddr,
	input  wire logic [pud_pkg::DATA_W-1:0] pwdata,
	output var  logic                       pready,
	output var  logic [pud_pkg::DATA_W-1:0] prdata,
	output var  logic                       pslverr,
	input  wire logic [pud_pkg::MODE_W-1:0] mode_pins,
	input  wire logic                       hw_standby_n,
	input  wire logic                       sw_standby,
	output var  logic [PORT_W-1:0]          port_e_pullup_en,
	output var  logic [PORT_W-1:0]          port_e_oe,
	output var  logic [PORT_W-1:0]          port_f_oe,
	output var  logic                       port_f_pin_seven_clk_sel
);

	pud_pkg::pud_apb_req_t         req;
	logic [PORT_W-1:0]             port_e_direction_bits;
	logic [PORT_W-1:0]             port_e_pullup_ctrl;
	logic [PORT_W-1:0]             port_f_direction_bits;
	pud_pkg::pud_ctrl_t            ctrl;
	logic [pud_pkg::MODE_W-1:0]    op_mode;
	logic [2:0]                    strap_cnt;
	logic                          strap_done;
	logic [pud_pkg::MODE_W-1:0]    mode_sync;
	logic                          hw_standby_n_sync;
	logic                          hw_standby;
	logic                          access;
	logic                          mapped;

	logic [PORT_W-1:0]             next_pe_dir;
	logic [PORT_W-1:0]             next_pe_pcr;
	logic [PORT_W-1:0]             next_pf_dir;
	pud_pkg::pud_ctrl_t            next_ctrl;
	logic [pud_pkg::MODE_W-1:0]    next_op_mode;
	logic [2:0]                    next_strap_cnt;
	logic                          next_strap_done;
	logic                          next_pready;
	logic [pud_pkg::DATA_W-1:0]    next_prdata;
	logic                          next_pslverr;
	logic [PORT_W-1:0]             next_pullup;
	logic [PORT_W-1:0]             next_pe_oe;
	logic                          next_clk_sel;

	// Expanded modes hand port E to the data bus in 16-bit bus mode and pin seven to the clock when its direction bit is set.
	function automatic logic expanded(input logic [pud_pkg::MODE_W-1:0] m, input logic ext);
		expanded = (m == pud_pkg::MODE_1) || (m == pud_pkg::MODE_2) ||
			(m == pud_pkg::MODE_4) || ((m == pud_pkg::MODE_7) && ext);
	endfunction

	function automatic logic port_e_is_io(input logic [pud_pkg::MODE_W-1:0] m,
		input pud_pkg::pud_ctrl_t c);
		port_e_is_io = !expanded(m, c.ext_exp_en) || !c.bus16;
	endfunction

	pud_sync #(
		.W   (pud_pkg::MODE_W),
		.RST (pud_pkg::MODE_RST)
	) u_mode_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pclk_en (pclk_en),
		.din     (mode_pins),
		.dout    (mode_sync)
	);

	pud_sync #(
		.W   (1),
		.RST (1'b1)
	) u_stby_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pclk_en (pclk_en),
		.din     (hw_standby_n),
		.dout    (hw_standby_n_sync)
	);

	assign req        = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign hw_standby = !hw_standby_n_sync;
	assign access     = req.sel && req.enable && !pready;
	assign mapped     = (req.addr == pud_pkg::OFF_PE_DIR) || (req.addr == pud_pkg::OFF_PE_PCR) ||
		(req.addr == pud_pkg::OFF_PF_DIR) || (req.addr == pud_pkg::OFF_CTRL) ||
		(req.addr == pud_pkg::OFF_STATUS);

	// Register file, strap capture and APB answer.
	always_comb
	begin
		next_pe_dir     = port_e_direction_bits;
		next_pe_pcr     = port_e_pullup_ctrl;
		next_pf_dir     = port_f_direction_bits;
		next_ctrl       = ctrl;
		next_op_mode    = op_mode;
		next_strap_cnt  = strap_cnt;
		next_strap_done = strap_done;
		next_pready     = access;
		next_prdata     = pud_pkg::DATA_ZERO;
		next_pslverr    = access && !mapped;
		if (!strap_done)
		begin
			// The synchronised pins settle only after the fourth edge, so the
			// capture waits for the fifth; an earlier one latches the reset mode.
			next_strap_cnt = strap_cnt + 3'h1;
			if (strap_cnt == pud_pkg::STRAP_WAIT)
			begin
				// Pin seven leaves reset as clock output only in the expanded modes.
				next_strap_done = 1'b1;
				next_op_mode    = mode_sync;
				next_pf_dir[pud_pkg::PIN_SEVEN] = (mode_sync != pud_pkg::MODE_7);
			end
		end
		if (access && req.write)
		begin
			unique case (req.addr)
				pud_pkg::OFF_PE_DIR: next_pe_dir = req.wdata[PORT_W-1:0];
				pud_pkg::OFF_PE_PCR: next_pe_pcr = req.wdata[PORT_W-1:0];
				pud_pkg::OFF_PF_DIR: next_pf_dir = req.wdata[PORT_W-1:0];
				pud_pkg::OFF_CTRL:
				begin
					next_ctrl.bus16 = req.wdata[pud_pkg::CTRL_BUS16];
					next_ctrl.ext_exp_en = req.wdata[pud_pkg::CTRL_EXT_EN];
				end
				default: next_ctrl = ctrl;
			endcase
		end
		else if (access)
		begin
			// The port F direction register reads as zero; software must not rely on it.
			unique case (req.addr)
				pud_pkg::OFF_PE_DIR: next_prdata[PORT_W-1:0] = port_e_direction_bits;
				pud_pkg::OFF_PE_PCR: next_prdata[PORT_W-1:0] = port_e_pullup_ctrl;
				pud_pkg::OFF_PF_DIR: next_prdata = pud_pkg::DATA_ZERO;
				pud_pkg::OFF_CTRL:
				begin
					next_prdata[pud_pkg::CTRL_BUS16] = ctrl.bus16;
					next_prdata[pud_pkg::CTRL_EXT_EN] = ctrl.ext_exp_en;
				end
				pud_pkg::OFF_STATUS:
				begin
					next_prdata[pud_pkg::ST_PULLUP +: PORT_W]        = port_e_pullup_en;
					next_prdata[pud_pkg::ST_MODE +: pud_pkg::MODE_W] = op_mode;
					next_prdata[pud_pkg::ST_HWSTBY]                  = hw_standby;
					next_prdata[pud_pkg::ST_SWSTBY]                  = sw_standby;
				end
				default: next_prdata = pud_pkg::DATA_ZERO;
			endcase
		end
	end

	// Pin controls are computed from the next register values so that they
	// change on the same edge as the write; software standby leaves them as is.
	always_comb
	begin
		next_pullup  = '0;
		next_pe_oe   = '0;
		if (port_e_is_io(next_op_mode, next_ctrl) && !hw_standby)
		begin
			next_pullup = ~next_pe_dir & next_pe_pcr;
			next_pe_oe  = next_pe_dir;
		end
		next_clk_sel = expanded(next_op_mode, next_ctrl.ext_exp_en) &&
			next_pf_dir[pud_pkg::PIN_SEVEN];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_e_direction_bits    <= pud_pkg::PORT_RST;
			port_e_pullup_ctrl       <= pud_pkg::PORT_RST;
			port_f_direction_bits    <= pud_pkg::PORT_RST;
			ctrl                     <= pud_pkg::CTRL_RST;
			op_mode                  <= pud_pkg::MODE_RST;
			strap_cnt                <= '0;
			strap_done               <= 1'b0;
			pready                   <= 1'b0;
			prdata                   <= pud_pkg::DATA_ZERO;
			pslverr                  <= 1'b0;
			port_e_pullup_en         <= pud_pkg::PORT_RST;
			port_e_oe                <= pud_pkg::PORT_RST;
			port_f_oe                <= pud_pkg::PORT_RST;
			port_f_pin_seven_clk_sel <= 1'b0;
		end
		else if (pclk_en)
		begin
			port_e_direction_bits    <= next_pe_dir;
			port_e_pullup_ctrl       <= next_pe_pcr;
			port_f_direction_bits    <= next_pf_dir;
			ctrl                     <= next_ctrl;
			op_mode                  <= next_op_mode;
			strap_cnt                <= next_strap_cnt;
			strap_done               <= next_strap_done;
			pready                   <= next_pready;
			prdata                   <= next_prdata;
			pslverr                  <= next_pslverr;
			port_e_pullup_en         <= next_pullup;
			port_e_oe                <= next_pe_oe;
			port_f_oe                <= next_pf_dir;
			port_f_pin_seven_clk_sel <= next_clk_sel;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !pclk_en);

	AST_BUS16_OFF: assert property (expanded(op_mode, ctrl.ext_exp_en) && ctrl.bus16
		|-> port_e_pullup_en == '0)
		else $error("pull-up active in 16-bit bus mode");

	AST_PCR_WRITE: assert property (access && req.write && req.addr == pud_pkg::OFF_PE_PCR
		&& port_e_is_io(op_mode, ctrl) && !hw_standby ##1 !hw_standby
		|-> port_e_pullup_en == (~port_e_direction_bits & $past(req.wdata[PORT_W-1:0])))
		else $error("pull-up did not follow pull-up control write");

	AST_HW_STANDBY: assert property (hw_standby && $past(hw_standby)
		|-> port_e_pullup_en == '0)
		else $error("pull-up active in hardware standby");

	AST_ON_OFF: assert property (port_e_is_io(op_mode, ctrl) && !hw_standby
		&& $stable(hw_standby) |-> port_e_pullup_en == (~port_e_direction_bits & port_e_pullup_ctrl))
		else $error("pull-up does not match direction and control bits");

	AST_PF_DIR: assert property (access && req.write && req.addr == pud_pkg::OFF_PF_DIR
		|=> port_f_oe == $past(req.wdata[PORT_W-1:0]))
		else $error("port F direction write not applied");

	AST_PF_READ: assert property (access && !req.write && req.addr == pud_pkg::OFF_PF_DIR
		|=> pready && prdata == pud_pkg::DATA_ZERO && !pslverr)
		else $error("port F direction read answered wrongly");

	AST_PE_OE: assert property (port_e_is_io(op_mode, ctrl) && !hw_standby
		&& $stable(hw_standby) |-> port_e_oe == port_e_direction_bits)
		else $error("port E output enable differs from direction bits");

	AST_CLK_SEL: assert property (strap_done
		|-> port_f_pin_seven_clk_sel ==
		(expanded(op_mode, ctrl.ext_exp_en) && port_f_direction_bits[pud_pkg::PIN_SEVEN]))
		else $error("pin seven clock select wrong");

	AST_APB_WAIT: assert property (access |=> pready ##1 !pready)
		else $error("APB answer not one cycle long");

	AST_IDLE_BUS: assert property (!pready |-> prdata == pud_pkg::DATA_ZERO && !pslverr)
		else $error("bus answer outside the ready cycle");

	AST_UNMAPPED: assert property (access && !mapped
		|=> pready && pslverr && prdata == pud_pkg::DATA_ZERO)
		else $error("unmapped access answered wrongly");

	AST_NO_STRAY_WRITE: assert property (access && req.write && !mapped
		|=> $stable(port_e_direction_bits) && $stable(port_e_pullup_ctrl) && $stable(ctrl))
		else $error("unmapped write changed a register");

	AST_STRAP_PIN7: assert property ($rose(strap_done)
		|-> port_f_direction_bits[pud_pkg::PIN_SEVEN] == (op_mode != pud_pkg::MODE_7))
		else $error("pin seven direction not set from the mode strap");

	AST_SW_STANDBY: assert property (sw_standby && port_e_is_io(op_mode, ctrl)
		&& !hw_standby && $stable(hw_standby)
		|-> port_e_pullup_en == (~port_e_direction_bits & port_e_pullup_ctrl))
		else $error("pull-up changed by software standby");

	AST_STANDBY_OE: assert property (hw_standby && $past(hw_standby)
		|-> port_e_oe == '0)
		else $error("port E driven in hardware standby");

	AST_BUS16_OE: assert property (expanded(op_mode, ctrl.ext_exp_en) && ctrl.bus16
		|-> port_e_oe == '0)
		else $error("port E driven while it carries the data bus");

	COV_PULLUP_ON: cover property (port_e_pullup_en != '0);
	COV_BUS16: cover property (ctrl.bus16 && expanded(op_mode, ctrl.ext_exp_en));
	COV_STANDBY: cover property (hw_standby && port_e_pullup_ctrl != '0);
	COV_CLK_SEL: cover property (port_f_pin_seven_clk_sel);
	COV_SW_STANDBY: cover property (sw_standby && port_e_pullup_en != '0);

endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the port pull-up and direction block.
 * Assumes the block answers APB with pready and drives its pins from registers.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        pclk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0]  mode_pins = 3'h7;
	logic        hw_standby_n = 1'b1;
	logic        sw_standby = 1'b0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [7:0]  pu;
	logic [7:0]  e_oe;
	logic [7:0]  f_oe;
	logic        clk_sel;
	logic [31:0] rdv;
	logic        errv;
	int          failures = 0;
	int          samples_checked = 0;

	pud_port dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .mode_pins(mode_pins),
		.hw_standby_n(hw_standby_n), .sw_standby(sw_standby), .port_e_pullup_en(pu),
		.port_e_oe(e_oe), .port_f_oe(f_oe), .port_f_pin_seven_clk_sel(clk_sel));

	always #5 pclk = ~pclk;

	task automatic give_verdict();
		$display("compares %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask

	// The request is held until the edge at which pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		chk(pready, 1'b1, "pready");
		if (pready !== 1'b1)
			give_verdict();
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic do_reset(input logic [2:0] m);
		@(posedge pclk);
		presetn <= 1'b0;
		mode_pins <= m;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		chk({pu, e_oe, f_oe, clk_sel, pready}, 32'h0000_0000, "outputs in reset");
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic t_pullup();
		logic [7:0] dirs [3] = '{8'h0F, 8'h00, 8'hFF};
		logic [7:0] pcrs [3] = '{8'h3C, 8'hFF, 8'hA5};
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, pud_pkg::OFF_PE_DIR, {24'h00_0000, dirs[i]});
			apb(1'b1, pud_pkg::OFF_PE_PCR, {24'h00_0000, pcrs[i]});
			chk(pu, ~dirs[i] & pcrs[i], "pullup per pin");
			chk(e_oe, dirs[i], "port e direction");
			apb(1'b0, pud_pkg::OFF_PE_PCR, 32'h0000_0000);
			chk(rdv, {24'h00_0000, pcrs[i]}, "pullup ctrl readback");
		end
		apb(1'b1, pud_pkg::OFF_PE_DIR, 32'h0000_0000);
		@(posedge pclk);
		sw_standby <= 1'b1;
		apb(1'b0, pud_pkg::OFF_STATUS, 32'h0000_0000);
		chk(rdv[pud_pkg::ST_SWSTBY], 1'b1, "sw standby status");
		chk(rdv[7:0], 8'hA5, "status pullups in sw standby");
		chk(pu, 8'hA5, "pullup in sw standby");
		@(posedge pclk);
		sw_standby <= 1'b0;
	endtask

	task automatic t_bus();
		apb(1'b1, pud_pkg::OFF_PE_DIR, 32'h0000_0000);
		apb(1'b1, pud_pkg::OFF_PE_PCR, 32'h0000_005A);
		apb(1'b1, pud_pkg::OFF_CTRL, 32'h0000_0003);
		chk(pu, 8'h00, "16-bit bus pullup");
		chk(e_oe, 8'h00, "16-bit bus oe");
		apb(1'b1, pud_pkg::OFF_CTRL, 32'h0000_0002);
		chk(pu, 8'h5A, "8-bit bus pullup");
	endtask

	task automatic t_port_f_pin_state();
		apb(1'b1, pud_pkg::OFF_PF_DIR, 32'h0000_00A5);
		chk(f_oe, 8'hA5, "port f direction");
		chk(clk_sel, 1'b1, "pin seven clock");
		apb(1'b0, pud_pkg::OFF_PF_DIR, 32'h0000_0000);
		chk(rdv, 32'h0000_0000, "port f read");
		apb(1'b1, pud_pkg::OFF_PF_DIR, 32'h0000_0025);
		chk({f_oe, clk_sel}, {8'h25, 1'b0}, "pin seven input");
		apb(1'b1, pud_pkg::OFF_PF_DIR, 32'h0000_0080);
		apb(1'b1, pud_pkg::OFF_CTRL, 32'h0000_0000);
		chk(clk_sel, 1'b0, "single chip pin seven");
	endtask

	task automatic t_unmapped();
		apb(1'b1, 8'h20, 32'h0000_00FF);
		chk(errv, 1'b1, "unmapped write error");
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(errv, 1'b1, "unmapped read error");
		chk(rdv, 32'h0000_0000, "unmapped read data");
		apb(1'b0, pud_pkg::OFF_PE_PCR, 32'h0000_0000);
		chk(errv, 1'b0, "mapped read after error");
		chk(rdv, 32'h0000_005A, "pullup ctrl after error");
	endtask

	task automatic wait_pu(input logic [7:0] exp);
		int n;
		n = 0;
		while (pu !== exp && n < 12)
		begin
			@(negedge pclk);
			n++;
		end
		chk(pu, exp, "pullup after standby edge");
		if (pu !== exp)
			give_verdict();
	endtask

	task automatic t_hwstby();
		apb(1'b1, pud_pkg::OFF_PE_DIR, 32'h0000_0000);
		apb(1'b1, pud_pkg::OFF_PE_PCR, 32'h0000_00FF);
		@(posedge pclk);
		hw_standby_n <= 1'b0;
		wait_pu(8'h00);
		@(posedge pclk);
		hw_standby_n <= 1'b1;
		wait_pu(8'hFF);
	endtask

	// A low clock enable freezes the synchroniser, so standby must not be seen.
	task automatic t_freeze();
		@(posedge pclk);
		pclk_en <= 1'b0;
		hw_standby_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(pu, 8'hFF, "pullup frozen while clock enable low");
		pclk_en <= 1'b1;
		wait_pu(8'h00);
		@(posedge pclk);
		hw_standby_n <= 1'b1;
		wait_pu(8'hFF);
	endtask

	// Modes 1, 2 and 4 are always expanded, so the bus width decides.
	task automatic t_modes();
		logic [2:0] ms [3] = '{pud_pkg::MODE_1, pud_pkg::MODE_2, pud_pkg::MODE_4};
		for (int i = 0; i < 3; i++)
		begin
			do_reset(ms[i]);
			chk({f_oe, clk_sel}, {8'h80, 1'b1}, "expanded pin seven");
			apb(1'b1, pud_pkg::OFF_PE_PCR, 32'h0000_00C3);
			apb(1'b1, pud_pkg::OFF_CTRL, 32'h0000_0001);
			chk(pu, 8'h00, "16-bit bus pullup");
			apb(1'b1, pud_pkg::OFF_CTRL, 32'h0000_0000);
			chk(pu, 8'hC3, "8-bit bus pullup");
			apb(1'b0, pud_pkg::OFF_STATUS, 32'h0000_0000);
			chk(rdv[10:8], ms[i], "mode status");
		end
	endtask

	initial
	begin
		do_reset(pud_pkg::MODE_7);
		chk({f_oe, clk_sel}, 9'h000, "mode 7 port f reset");
		t_pullup();
		t_bus();
		t_port_f_pin_state();
		t_unmapped();
		t_hwstby();
		t_freeze();
		t_modes();
		give_verdict();
	end
endmodule

`default_nettype wire
